//--- src/variable_cycle_pwm_pair.sv
// two variable-cycle pwm timer pairs with an ahb-lite register slave
// assumes a single master, zero wait states, word accesses only
`timescale 1ns/100ps
`default_nettype none

module variable_cycle_pwm_pair (
	// clock and reset
	input  wire logic                         clock_i,
	input  wire logic                         resetn_i,
	// ahb-lite slave
	input  wire logic                         hsel_i,
	input  wire logic [31:0]                  haddr_i,
	input  wire logic [1:0]                   htrans_i,
	input  wire logic                         hwrite_i,
	input  wire logic [2:0]                   hsize_i,
	input  wire logic [vcpwm_pkg::DATA_W-1:0] hwdata_i,
	input  wire logic                         hready_i,
	output logic      [vcpwm_pkg::DATA_W-1:0] hrdata_o,
	output logic                              hreadyout_o,
	output logic                              hresp_o,
	// pwm pins and interrupt
	output logic                              pair0_pwm_pin_o,
	output logic                              pair1_pwm_pin_o,
	output logic                              irq_o
);
	import vcpwm_pkg::*;

	state_s q;
	state_s d;

	logic [NUM_PAIRS-1:0] tick_w;
	logic [NUM_PAIRS-1:0] active_w;
	logic [NUM_PAIRS-1:0] start_w;
	logic [NUM_PAIRS-1:0] lower_hit_w;
	logic [NUM_PAIRS-1:0] upper_hit_w;
	logic [7:0]           lower_next_w [NUM_PAIRS];
	logic [7:0]           upper_next_w [NUM_PAIRS];
	logic [7:0]           base;
	logic [3:0]           irq_set;
	logic [3:0]           irq_clr;
	logic                 addr_phase;
	logic                 mapped;

	function automatic logic [31:0] read_reg(input state_s s, input logic [7:0] a);
		logic [7:0] v;
		logic [7:0] b;
		v = 8'h00;
		b = 8'h00;
		for (int i = 0; i < NUM_PAIRS; i++) begin
			b = 8'(i) * PAIR_STRIDE;
			if (a == b + OFF_LOWER_MODE_CTRL)
				v = s.p[i].lower_mode;
			if (a == b + OFF_UPPER_MODE_CTRL)
				v = s.p[i].upper_mode;
			if (a == b + OFF_LOWER_RUN_STATUS)
				v = {s.p[i].lower_run[7:6], s.irq_mask[2*i], 2'b00, s.irq_status[2*i], s.p[i].lower_run[1:0]};
			if (a == b + OFF_UPPER_RUN_STATUS)
				v = {s.p[i].upper_run[7:6], s.irq_mask[2*i+1], 2'b00, s.irq_status[2*i+1],
					s.p[i].upper_run[1:0]};
			if (a == b + OFF_SHARED_CTRL)
				v = {1'b0, s.p[i].level, s.p[i].shared[5:0]};
			if (a == b + OFF_LOW_WIDTH_VALUE)
				v = s.p[i].low_width;
			if (a == b + OFF_PERIOD_VALUE)
				v = s.p[i].period;
		end
		if (a == OFF_IRQ_STATUS)
			v = {4'h0, s.irq_status};
		if (a == OFF_IRQ_MASK)
			v = {4'h0, s.irq_mask};
		return {24'h00_0000, v};
	endfunction : read_reg

	// per-pair count tick and comparators
	for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_pair
		logic [6:0] div_mask;
		// both counters use the lower timer's clock select, the upper one must match it
		assign div_mask = 7'((8'h01 << q.p[g].lower_mode[CLK_SEL_LSB +: 3]) - 8'h01);
		assign tick_w[g] = ((q.presc & div_mask) == div_mask);
		assign active_w[g] = (q.p[g].lower_run[RUN_ENABLE_BIT] | q.p[g].upper_run[RUN_ENABLE_BIT])
			&& (q.p[g].lower_mode[OP_SEL_LSB +: 4] == OP_VAR_PWM);
		assign start_w[g] = active_w[g] && !q.p[g].active;
		assign lower_next_w[g] = q.p[g].lower_cnt + 8'h01;
		assign upper_next_w[g] = q.p[g].upper_cnt + 8'h01;
		assign lower_hit_w[g] = active_w[g] && !start_w[g] && tick_w[g]
			&& (lower_next_w[g] == q.p[g].lower_latch);
		assign upper_hit_w[g] = active_w[g] && !start_w[g] && tick_w[g]
			&& (upper_next_w[g] == q.p[g].upper_latch);

		chk_start_low: assert property (@(posedge clock_i) disable iff (!resetn_i)
			start_w[g] |=> !q.p[g].level && q.p[g].lower_cnt == 8'h00 && q.p[g].upper_cnt == 8'h00)
			else $error("first period did not start low with cleared counters");
		chk_latch_load: assert property (@(posedge clock_i) disable iff (!resetn_i)
			start_w[g] |=> q.p[g].upper_latch == $past(q.p[g].period)
				&& q.p[g].lower_latch == $past(q.p[g].low_width))
			else $error("compare latches not loaded at start");
		chk_cascade_clear: assert property (@(posedge clock_i) disable iff (!resetn_i)
			(q.wr_pend && hwdata_i[RUN_ENABLE_BIT]
				&& q.wr_addr == 8'(g) * PAIR_STRIDE + OFF_UPPER_RUN_STATUS)
			|=> !q.p[g].shared[CASCADE_SELECT_BIT])
			else $error("run enable did not clear cascade select");
		chk_width_high: assert property (@(posedge clock_i) disable iff (!resetn_i)
			lower_hit_w[g] && !upper_hit_w[g] |=> q.p[g].level
				&& q.p[g].lower_latch == $past(q.p[g].low_width))
			else $error("width match did not drive the pin high");
		chk_period_restart: assert property (@(posedge clock_i) disable iff (!resetn_i)
			upper_hit_w[g] |=> !q.p[g].level && q.p[g].upper_cnt == 8'h00
				&& q.p[g].lower_cnt == 8'h00)
			else $error("period match did not restart low");
		chk_never_high: assert property (@(posedge clock_i) disable iff (!resetn_i)
			(active_w[g] && !start_w[g] && !q.p[g].level && q.p[g].upper_latch != 8'h00
				&& q.p[g].lower_latch > q.p[g].upper_latch) |=> !q.p[g].level)
			else $error("pin went high with width above period");
		chk_stop_freeze: assert property (@(posedge clock_i) disable iff (!resetn_i)
			!active_w[g] |=> $stable(q.p[g].level))
			else $error("output moved while stopped");
		chk_flag_set: assert property (@(posedge clock_i) disable iff (!resetn_i)
			lower_hit_w[g] |=> q.irq_status[2*g])
			else $error("width match did not set its flag");
		chk_latch_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
			(active_w[g] && !start_w[g] && !upper_hit_w[g]) |=> $stable(q.p[g].upper_latch))
			else $error("period latch changed without a match");

		cov_start: cover property (@(posedge clock_i) disable iff (!resetn_i) start_w[g]);
		cov_high_then_period: cover property (@(posedge clock_i) disable iff (!resetn_i)
			lower_hit_w[g] ##[1:300] upper_hit_w[g]);
		cov_stop_high: cover property (@(posedge clock_i) disable iff (!resetn_i)
			q.p[g].active && !active_w[g] && q.p[g].level);
	end

	assign addr_phase = hsel_i && htrans_i[1] && hready_i;
	assign mapped     = (haddr_i[31:ADDR_W] == 24'h00_0000);

	always_comb begin
		d = q;
		base = 8'h00;
		irq_set = 4'h0;
		irq_clr = 4'h0;
		d.presc = q.presc + 7'h01;

		// data phase of a write
		if (q.wr_pend) begin
			if (q.wr_addr == OFF_IRQ_STATUS)
				irq_clr = hwdata_i[3:0];
			if (q.wr_addr == OFF_IRQ_MASK)
				d.irq_mask = hwdata_i[3:0];
			for (int i = 0; i < NUM_PAIRS; i++) begin
				base = 8'(i) * PAIR_STRIDE;
				if (q.wr_addr == base + OFF_LOWER_MODE_CTRL)
					d.p[i].lower_mode = hwdata_i[7:0];
				if (q.wr_addr == base + OFF_UPPER_MODE_CTRL)
					d.p[i].upper_mode = hwdata_i[7:0];
				if (q.wr_addr == base + OFF_SHARED_CTRL)
					d.p[i].shared = hwdata_i[7:0] & SHARED_RW_MASK;
				if (q.wr_addr == base + OFF_LOW_WIDTH_VALUE)
					d.p[i].low_width = hwdata_i[7:0];
				if (q.wr_addr == base + OFF_PERIOD_VALUE)
					d.p[i].period = hwdata_i[7:0];
				if (q.wr_addr == base + OFF_LOWER_RUN_STATUS) begin
					d.p[i].lower_run = hwdata_i[7:0] & RUN_STATUS_RW_MASK;
					d.irq_mask[2*i] = hwdata_i[MATCH_IRQ_ENABLE_BIT];
					if (hwdata_i[RUN_ENABLE_BIT])
						d.p[i].shared[CASCADE_SELECT_BIT] = 1'b0;
				end
				if (q.wr_addr == base + OFF_UPPER_RUN_STATUS) begin
					d.p[i].upper_run = hwdata_i[7:0] & RUN_STATUS_RW_MASK;
					d.irq_mask[2*i+1] = hwdata_i[MATCH_IRQ_ENABLE_BIT];
					if (hwdata_i[RUN_ENABLE_BIT])
						d.p[i].shared[CASCADE_SELECT_BIT] = 1'b0;
				end
			end
		end

		// pwm engines, one per pair
		for (int i = 0; i < NUM_PAIRS; i++) begin
			d.p[i].active = active_w[i];
			// the pair's counters are both busy, so a wide cascade cannot form
			if (active_w[i])
				d.p[i].shared[CASCADE_SELECT_BIT] = 1'b0;
			if (start_w[i]) begin
				d.p[i].lower_cnt   = 8'h00;
				d.p[i].upper_cnt   = 8'h00;
				d.p[i].lower_latch = q.p[i].low_width;
				d.p[i].upper_latch = q.p[i].period;
				d.p[i].level       = 1'b0;
			end else if (upper_hit_w[i]) begin
				d.p[i].lower_cnt   = 8'h00;
				d.p[i].upper_cnt   = 8'h00;
				d.p[i].upper_latch = q.p[i].period;
				// lower latch reloads here too, else a width above the period could never be replaced
				d.p[i].lower_latch = q.p[i].low_width;
				d.p[i].level       = 1'b0;
			end else if (active_w[i] && tick_w[i]) begin
				d.p[i].lower_cnt = lower_next_w[i];
				d.p[i].upper_cnt = upper_next_w[i];
				if (lower_hit_w[i]) begin
					d.p[i].lower_latch = q.p[i].low_width;
					d.p[i].level       = 1'b1;
				end
			end
			irq_set[2*i]   = lower_hit_w[i];
			irq_set[2*i+1] = upper_hit_w[i];
		end

		// a match in the clearing cycle survives
		d.irq_status = (q.irq_status & ~irq_clr) | irq_set;

		// address phase
		d.wr_pend = addr_phase && hwrite_i && mapped;
		d.wr_addr = haddr_i[ADDR_W-1:0];
		if (addr_phase && !hwrite_i)
			d.rdata = mapped ? read_reg(d, haddr_i[ADDR_W-1:0]) : 32'h0000_0000;
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < NUM_PAIRS; i++) begin
				q.p[i] <= '{RST_BYTE, RST_BYTE, RST_BYTE, RST_BYTE, RST_BYTE, RST_BYTE, RST_BYTE,
					RST_BYTE, RST_BYTE, RST_BYTE, RST_BYTE, 1'b0, 1'b0};
			end
			q.presc      <= RST_PRESC;
			q.irq_status <= RST_IRQ;
			q.irq_mask   <= RST_IRQ;
			q.wr_pend    <= 1'b0;
			q.wr_addr    <= RST_BYTE;
			q.rdata      <= 32'h0000_0000;
		end else begin
			q <= d;
		end
	end

	// zero wait states, only okay answers
	assign hreadyout_o     = 1'b1;
	assign hresp_o         = 1'b0;
	assign hrdata_o        = q.rdata;
	assign pair0_pwm_pin_o = q.p[0].level;
	assign pair1_pwm_pin_o = q.p[1].level;
	assign irq_o           = |(q.irq_status & q.irq_mask);

endmodule : variable_cycle_pwm_pair

`default_nettype wire

//--- common/vcpwm_pkg.sv
// constants and state types for the variable-cycle pwm timer pairs
// assumes one 10 mhz clock and a 32-bit ahb-lite register bus
package vcpwm_pkg;

	localparam int unsigned NUM_PAIRS  = 2;
	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned CLOCK_HZ   = 10_000_000;

	// byte offsets inside one pair, pair n sits at n * PAIR_STRIDE; the irq status and mask offsets are global, past the pairs
	localparam logic [7:0] OFF_LOWER_MODE_CTRL  = 8'h00;
	localparam logic [7:0] OFF_UPPER_MODE_CTRL  = 8'h04;
	localparam logic [7:0] OFF_LOWER_RUN_STATUS = 8'h08;
	localparam logic [7:0] OFF_UPPER_RUN_STATUS = 8'h0C;
	localparam logic [7:0] OFF_SHARED_CTRL      = 8'h10;
	localparam logic [7:0] OFF_LOW_WIDTH_VALUE  = 8'h14;
	localparam logic [7:0] OFF_PERIOD_VALUE     = 8'h18;
	localparam logic [7:0] PAIR_STRIDE          = 8'h20;
	localparam logic [7:0] OFF_IRQ_STATUS       = 8'h40;
	localparam logic [7:0] OFF_IRQ_MASK         = 8'h44;

	// field positions
	localparam int unsigned RUN_ENABLE_BIT         = 7;
	localparam int unsigned MATCH_IRQ_ENABLE_BIT   = 5;
	localparam int unsigned MATCH_FLAG_BIT         = 2;
	localparam int unsigned CASCADE_SELECT_BIT     = 4;
	localparam int unsigned LOWER_OUTPUT_LEVEL_BIT = 6;
	localparam int unsigned CLK_SEL_LSB            = 4;
	localparam int unsigned OP_SEL_LSB             = 0;

	localparam logic [7:0] RUN_STATUS_RW_MASK = 8'hC3;
	localparam logic [7:0] SHARED_RW_MASK     = 8'h3F;
	localparam logic [3:0] OP_VAR_PWM         = 4'h4;

	// reset values
	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam logic [6:0] RST_PRESC = 7'h00;
	localparam logic [3:0] RST_IRQ   = 4'h0;

	typedef struct packed {
		logic [7:0] lower_mode;
		logic [7:0] upper_mode;
		logic [7:0] lower_run;
		logic [7:0] upper_run;
		logic [7:0] shared;
		logic [7:0] low_width;
		logic [7:0] period;
		logic [7:0] lower_cnt;
		logic [7:0] upper_cnt;
		logic [7:0] lower_latch;
		logic [7:0] upper_latch;
		logic       level;
		logic       active;
	} pair_s;

	typedef struct packed {
		pair_s [NUM_PAIRS-1:0] p;
		logic [6:0]            presc;
		logic [3:0]            irq_status;
		logic [3:0]            irq_mask;
		logic                  wr_pend;
		logic [7:0]            wr_addr;
		logic [31:0]           rdata;
	} state_s;

endpackage : vcpwm_pkg

//--- verif/tb_variable_cycle_pwm_pair.sv
// bench for the variable-cycle pwm pairs: ahb-lite register tasks and pin checks
// assumes zero wait states but still waits on hready; single slave, hready fed back
`timescale 1ns/100ps
`default_nettype none

module tb_variable_cycle_pwm_pair;
	import vcpwm_pkg::*;

	logic        clock_i;
	logic        resetn_i;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	logic        pin0;
	logic        pin1;
	logic        irq;
	logic [31:0] rd;
	int          err_count;
	int          check_count;
	int          cyc;
	int          hi;

	variable_cycle_pwm_pair dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(), .pair0_pwm_pin_o(pin0),
		.pair1_pwm_pin_o(pin1), .irq_o(irq));

	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	// a hang must still reach the verdict
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic bus(input logic [31:0] a, input logic wr, input logic [7:0] d);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clock_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= {24'h00_0000, d};
		do @(posedge clock_i); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		bus(a, 1'b1, d);
	endtask : wr

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
		bus(a, 1'b0, 8'h00);
		check(rd & m, e, w);
	endtask : rd_chk

	// high cycles of one pin over n clocks
	task automatic count_high(input int which, input int n);
		hi = 0;
		repeat (n) begin
			@(posedge clock_i);
			if ((which == 0 ? pin0 : pin1) === 1'b1) hi++;
		end
	endtask : count_high

	initial begin
		resetn_i = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
		err_count = 0;
		check_count = 0;
		cyc = 0;
		repeat (6) @(posedge clock_i);
		resetn_i <= 1'b1;
		@(posedge clock_i);
		check({31'h0, pin0 | pin1 | irq}, 32'h0000_0000, "outputs after reset");
		rd_chk({24'h0, OFF_PERIOD_VALUE}, 32'hFFFF_FFFF, 32'h0000_0000, "period reset");
		wr(32'h0000_0080, 8'h5A);
		rd_chk(32'h0000_0080, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
		$display("test reset and map done");

		wr({24'h0, OFF_PERIOD_VALUE}, 8'h04);
		wr({24'h0, OFF_LOW_WIDTH_VALUE}, 8'h02);
		wr({24'h0, OFF_LOWER_MODE_CTRL}, {4'h0, OP_VAR_PWM});
		wr({24'h0, OFF_SHARED_CTRL}, 8'h10);
		wr({24'h0, OFF_IRQ_MASK}, 8'h01);
		wr({24'h0, OFF_LOWER_RUN_STATUS}, 8'hA0);
		check({31'h0, pin0}, 32'h0000_0000, "first period low");
		repeat (10) @(posedge clock_i);
		count_high(0, 40);
		check(hi, 20, "pair0 high time p4 w2");
		rd_chk({24'h0, OFF_SHARED_CTRL}, 32'h0000_0010, 32'h0000_0000, "cascade cleared");
		rd_chk({24'h0, OFF_IRQ_STATUS}, 32'h0000_0003, 32'h0000_0003, "both flags");
		rd_chk({24'h0, OFF_LOWER_RUN_STATUS}, 32'h0000_0004, 32'h0000_0004, "lower flag alias");
		check({31'h0, irq}, 32'h0000_0001, "irq unmasked");
		$display("test basic pwm done");

		wr({24'h0, OFF_LOW_WIDTH_VALUE}, 8'h06);
		repeat (20) @(posedge clock_i);
		count_high(0, 40);
		check(hi, 0, "width above period");
		wr({24'h0, OFF_LOW_WIDTH_VALUE}, 8'h01);
		count_high(0, 2);
		check(hi, 0, "new width not immediate");
		repeat (20) @(posedge clock_i);
		count_high(0, 40);
		check(hi, 30, "new width after match");
		$display("test data update done");

		wr({24'h0, OFF_LOWER_RUN_STATUS}, 8'h00);
		hi = {31'h0, pin0};
		repeat (20) begin
			@(posedge clock_i);
			check({31'h0, pin0}, hi, "frozen level");
		end
		rd_chk({24'h0, OFF_SHARED_CTRL}, 32'h0000_0040, {25'h0, hi[0], 6'h0}, "level bit");
		wr({24'h0, OFF_IRQ_STATUS}, 8'h0F);
		rd_chk({24'h0, OFF_IRQ_STATUS}, 32'h0000_000F, 32'h0000_0000, "flags cleared");
		check({31'h0, irq}, 32'h0000_0000, "irq cleared");
		wr({24'h0, OFF_UPPER_RUN_STATUS}, 8'h80);
		repeat (2) @(posedge clock_i);
		check({31'h0, pin0}, 32'h0000_0000, "restart low");
		$display("test stop and restart done");

		wr({24'h0, PAIR_STRIDE + OFF_PERIOD_VALUE}, 8'h08);
		wr({24'h0, PAIR_STRIDE + OFF_LOW_WIDTH_VALUE}, 8'h02);
		wr({24'h0, PAIR_STRIDE + OFF_LOWER_MODE_CTRL}, {4'h0, OP_VAR_PWM});
		wr({24'h0, PAIR_STRIDE + OFF_LOWER_RUN_STATUS}, 8'h80);
		repeat (10) @(posedge clock_i);
		count_high(1, 40);
		check(hi, 30, "pair1 high time p8 w2");
		count_high(0, 40);
		check(hi, 30, "pair0 unaffected");
		$display("test second pair done");
		print_verdict();
	end

endmodule : tb_variable_cycle_pwm_pair

`default_nettype wire
